// ### flow_exec_defines.vh
// constants for the branch, call, return and port execution block
`ifndef FLOW_EXEC_DEFINES_VH
`define FLOW_EXEC_DEFINES_VH
// ****************************************
// opcodes
// ****************************************
`define OP_REL_JUMP 8'h18
`define OP_LOOP 8'h10
`define OP_CALL 8'hCD
`define OP_SUB_EXIT 8'hC9
`define OP_PREFIX 8'hED
`define OP_OUTN 8'hD3
`define OP_INN 8'hDB
`define OP_MSEXIT 8'h4D
`define OP_NMEXIT 8'h45
`define OP_IN_BLK_REP 8'hB2
`define OP_OUT_BLK_REP 8'hB3
`define OP_INI 8'hA2
`define OP_OUTI 8'hA3
// ****************************************
// flag positions and misc
// ****************************************
`define F_S 7
`define F_Z 6
`define F_PV 2
`define F_C 0
`define STACK_RESET 16'hFFFF
`define PROG_RESET 16'h0000
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define T_COND_FALSE_CALL 5'h0A
`define T_CALL 5'h11
`define T_EXIT_FALSE 5'h05
`define T_EXIT_TRUE 5'h0B
`define T_EXIT 5'h0A
`define T_SVC_EXIT 5'h0E
`define T_OUTN 5'h0B
`define T_REL_TAKEN 5'h0C
`define T_REL_NOT 5'h07
`define T_LOOP_TAKEN 5'h0D
`define T_LOOP_NOT 5'h08
`define T_BLK_REP 5'h15
`define T_BLK_LAST 5'h10
`define T_RST 5'h0B
`define M_BLK_REP 3'h5
`define M_BLK_LAST 3'h4
`define M_REL_TAKEN 3'h3
`define M_REL_NOT 3'h2
`endif

// ### word_fifo.v
// synchronous fifo with valid/ready on both sides
module word_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    input wire sys_clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    // honest full/empty from the occupancy count
    assign in_ready = (count_reg != DEPTH);
    assign out_valid = (count_reg != 0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // pointer and count update
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
    // storage has no reset; only valid words are read
    always @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end
endmodule // word_fifo

// ### flow_exec.v
// execution core for relative jumps, call/return/restart and port i/o
`include "flow_exec_defines.vh"
module flow_exec
(
    input wire sys_clk,
    input wire rst,
    input wire [7:0] op_byte,
    input wire [7:0] op_arg1,
    input wire [7:0] op_arg2,
    input wire op_valid,
    output reg op_ready,
    input wire [7:0] mem_rdata,
    input wire [7:0] port_rdata,
    input wire [7:0] acc_in,
    input wire nmi_entry,
    input wire ei_set,
    input wire di_clr,
    output reg [15:0] program_counter,
    output reg [15:0] stack_pointer,
    output reg [7:0] flags,
    output reg [7:0] b_count,
    output reg interrupt_enable_primary,
    output reg interrupt_enable_shadow,
    output reg [15:0] bus_addr,
    output reg [7:0] bus_wdata,
    output reg mem_wr,
    output reg mem_rd,
    output reg io_wr,
    output reg io_rd,
    output reg [4:0] t_states,
    output reg [2:0] m_cycles,
    output reg done,
    output reg [7:0] in_word,
    output reg in_word_valid,
    input wire in_word_ready
);
    // ****************************************
    // decode helpers
    // ****************************************
    // condition code evaluation, shared by jumps, calls and returns
    function cond_true;
        input [2:0] cc;
        input [7:0] f;
        begin
            case (cc)
                3'h0: cond_true = ~f[`F_Z];
                3'h1: cond_true = f[`F_Z];
                3'h2: cond_true = ~f[`F_C];
                3'h3: cond_true = f[`F_C];
                3'h4: cond_true = ~f[`F_PV];
                3'h5: cond_true = f[`F_PV];
                3'h6: cond_true = ~f[`F_S];
                default: cond_true = f[`F_S];
            endcase
        end
    endfunction
    // relative target: pc of the instruction plus two plus signed displacement
    function [15:0] rel_target;
        input [15:0] pc;
        input [7:0] disp;
        begin
            rel_target = pc + 16'h0002 + {{8{disp[7]}}, disp};
        end
    endfunction
    // ****************************************
    // states
    // ****************************************
    localparam S_IDLE = 3'h0;
    localparam S_PUSH_HI = 3'h1;
    localparam S_PUSH_LO = 3'h2;
    localparam S_POP_LO = 3'h3;
    localparam S_POP_HI = 3'h4;
    localparam S_BLK = 3'h5;
    localparam S_BLK_WAIT = 3'h6;
    localparam S_POP_END = 3'h7;
    reg [2:0] state_reg;
    reg [15:0] target_reg;
    reg [15:0] ret_pc_reg;
    reg [4:0] t_reg;
    reg [2:0] m_reg;
    reg repeat_reg;
    reg out_dir_reg;
    reg [15:0] hl_reg;
    reg [7:0] c_port_reg;
    reg [7:0] pop_lo_reg;
    reg nm_exit_reg;
    wire [7:0] b_dec;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire ed_pfx;
    wire [2:0] cc_field;
    assign b_dec = b_count - 8'h01;
    assign ed_pfx = (op_byte == `OP_PREFIX);
    assign cc_field = op_byte[5:3];
    // input words from block input steps are buffered toward the user
    word_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(port_rdata),
        .in_valid(state_reg == S_BLK && !out_dir_reg),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(in_word_ready && !in_word_valid)
    );
    // ****************************************
    // main sequencer
    // ****************************************
    // flags only change in block port steps; branches never touch them
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= S_IDLE;
            program_counter <= `PROG_RESET;
            stack_pointer <= `STACK_RESET;
            flags <= 8'h00;
            b_count <= 8'h00;
            interrupt_enable_primary <= 1'b0;
            interrupt_enable_shadow <= 1'b0;
            bus_addr <= 16'h0000;
            bus_wdata <= 8'h00;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            io_wr <= 1'b0;
            io_rd <= 1'b0;
            t_states <= 5'h00;
            m_cycles <= 3'h0;
            done <= 1'b0;
            op_ready <= 1'b1;
            target_reg <= 16'h0000;
            ret_pc_reg <= 16'h0000;
            t_reg <= 5'h00;
            m_reg <= 3'h0;
            repeat_reg <= 1'b0;
            out_dir_reg <= 1'b0;
            hl_reg <= 16'h0000;
            c_port_reg <= 8'h00;
            pop_lo_reg <= 8'h00;
            nm_exit_reg <= 1'b0;
        end
        else
        begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            io_wr <= 1'b0;
            io_rd <= 1'b0;
            done <= 1'b0;
            // interrupt enables: nmi saves primary into shadow
            if (nmi_entry)
            begin
                interrupt_enable_shadow <= interrupt_enable_primary;
                interrupt_enable_primary <= 1'b0;
            end
            else if (ei_set)
            begin
                interrupt_enable_primary <= 1'b1;
                interrupt_enable_shadow <= 1'b1;
            end
            else if (di_clr)
            begin
                interrupt_enable_primary <= 1'b0;
                interrupt_enable_shadow <= 1'b0;
            end
            case (state_reg)
                S_IDLE:
                begin
                    if (op_valid && op_ready)
                    begin
                        op_ready <= 1'b0;
                        done <= 1'b1;
                        if (op_byte == `OP_REL_JUMP)
                        begin
                            program_counter <= rel_target(program_counter,
                                op_arg1);
                            t_states <= `T_REL_TAKEN;
                            m_cycles <= `M_REL_TAKEN;
                            op_ready <= 1'b1;
                        end
                        else if (op_byte[7:5] == 3'h1 && op_byte[2:0] == 3'h0)
                        begin
                            // conditional relative jump, nz/z/nc/c only
                            op_ready <= 1'b1;
                            if (cond_true({1'b0, op_byte[4:3]}, flags))
                            begin
                                program_counter <= rel_target(
                                    program_counter, op_arg1);
                                t_states <= `T_REL_TAKEN;
                                m_cycles <= `M_REL_TAKEN;
                            end
                            else
                            begin
                                program_counter <= program_counter + 16'h0002;
                                t_states <= `T_REL_NOT;
                                m_cycles <= `M_REL_NOT;
                            end
                        end
                        else if (op_byte == `OP_LOOP)
                        begin
                            b_count <= b_dec;
                            op_ready <= 1'b1;
                            if (b_dec != 8'h00)
                            begin
                                program_counter <= rel_target(
                                    program_counter, op_arg1);
                                t_states <= `T_LOOP_TAKEN;
                                m_cycles <= `M_REL_TAKEN;
                            end
                            else
                            begin
                                program_counter <= program_counter + 16'h0002;
                                t_states <= `T_LOOP_NOT;
                                m_cycles <= `M_REL_NOT;
                            end
                        end
                        else if (op_byte == `OP_CALL ||
                            (op_byte[7:6] == 2'h3 && op_byte[2:0] == 3'h4))
                        begin
                            if (op_byte == `OP_CALL ||
                                cond_true(cc_field, flags))
                            begin
                                done <= 1'b0;
                                ret_pc_reg <= program_counter + 16'h0003;
                                target_reg <= {op_arg2, op_arg1};
                                t_reg <= `T_CALL;
                                m_reg <= 3'h5;
                                state_reg <= S_PUSH_HI;
                            end
                            else
                            begin
                                program_counter <= program_counter + 16'h0003;
                                t_states <= `T_COND_FALSE_CALL;
                                m_cycles <= 3'h3;
                                op_ready <= 1'b1;
                            end
                        end
                        else if (op_byte[7:6] == 2'h3 && op_byte[2:0] == 3'h7)
                        begin
                            done <= 1'b0;
                            ret_pc_reg <= program_counter + 16'h0001;
                            target_reg <= {8'h00, 2'h0, op_byte[5:3],
                                3'h0};
                            t_reg <= `T_RST;
                            m_reg <= 3'h3;
                            state_reg <= S_PUSH_HI;
                        end
                        else if (op_byte == `OP_SUB_EXIT ||
                            (op_byte[7:6] == 2'h3 && op_byte[2:0] == 3'h0))
                        begin
                            if (op_byte == `OP_SUB_EXIT ||
                                cond_true(cc_field, flags))
                            begin
                                done <= 1'b0;
                                nm_exit_reg <= 1'b0;
                                t_reg <= (op_byte == `OP_SUB_EXIT) ? `T_EXIT
                                    : `T_EXIT_TRUE;
                                m_reg <= 3'h3;
                                state_reg <= S_POP_LO;
                                mem_rd <= 1'b1;
                                bus_addr <= stack_pointer;
                            end
                            else
                            begin
                                program_counter <= program_counter + 16'h0001;
                                t_states <= `T_EXIT_FALSE;
                                m_cycles <= 3'h1;
                                op_ready <= 1'b1;
                            end
                        end
                        else if (ed_pfx && (op_arg1 == `OP_MSEXIT ||
                            op_arg1 == `OP_NMEXIT))
                        begin
                            done <= 1'b0;
                            nm_exit_reg <= (op_arg1 == `OP_NMEXIT);
                            t_reg <= `T_SVC_EXIT;
                            m_reg <= 3'h4;
                            state_reg <= S_POP_LO;
                            mem_rd <= 1'b1;
                            bus_addr <= stack_pointer;
                        end
                        else if (op_byte == `OP_OUTN)
                        begin
                            bus_addr <= {acc_in, op_arg1};
                            bus_wdata <= acc_in;
                            io_wr <= 1'b1;
                            program_counter <= program_counter + 16'h0002;
                            t_states <= `T_OUTN;
                            m_cycles <= 3'h3;
                            op_ready <= 1'b1;
                        end
                        else if (ed_pfx && (op_arg1 == `OP_IN_BLK_REP ||
                            op_arg1 == `OP_OUT_BLK_REP || op_arg1 == `OP_INI ||
                            op_arg1 == `OP_OUTI))
                        begin
                            // arg2 carries the port, b_count the length
                            done <= 1'b0;
                            repeat_reg <= op_arg1[4];
                            out_dir_reg <= op_arg1[0];
                            c_port_reg <= op_arg2;
                            state_reg <= S_BLK_WAIT;
                        end
                        else
                        begin
                            // unsupported: skip one byte
                            program_counter <= program_counter + 16'h0001;
                            op_ready <= 1'b1;
                        end
                    end
                end
                S_PUSH_HI:
                begin
                    bus_addr <= stack_pointer - 16'h0001;
                    bus_wdata <= ret_pc_reg[15:8];
                    mem_wr <= 1'b1;
                    state_reg <= S_PUSH_LO;
                end
                S_PUSH_LO:
                begin
                    bus_addr <= stack_pointer - 16'h0002;
                    bus_wdata <= ret_pc_reg[7:0];
                    mem_wr <= 1'b1;
                    stack_pointer <= stack_pointer - 16'h0002;
                    program_counter <= target_reg;
                    t_states <= t_reg;
                    m_cycles <= m_reg;
                    done <= 1'b1;
                    op_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_POP_LO:
                begin
                    // second read goes out in the same cycle the first byte is back
                    mem_rd <= 1'b1;
                    bus_addr <= stack_pointer + 16'h0001;
                    state_reg <= S_POP_HI;
                end
                S_POP_HI:
                begin
                    // read data stand only in the cycle after mem_rd
                    pop_lo_reg <= mem_rdata;
                    state_reg <= S_POP_END;
                end
                S_POP_END:
                begin
                    program_counter <= {mem_rdata, pop_lo_reg};
                    stack_pointer <= stack_pointer + 16'h0002;
                    if (nm_exit_reg)
                        interrupt_enable_primary <=
                            interrupt_enable_shadow;
                    t_states <= t_reg;
                    m_cycles <= m_reg;
                    done <= 1'b1;
                    op_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_BLK_WAIT:
                begin
                    // input steps stall while the fifo is full
                    if (out_dir_reg || fifo_in_ready)
                    begin
                        bus_addr <= {b_count, c_port_reg};
                        if (out_dir_reg)
                        begin
                            io_wr <= 1'b1;
                            bus_wdata <= mem_rdata;
                        end
                        else
                            io_rd <= 1'b1;
                        state_reg <= S_BLK;
                    end
                end
                S_BLK:
                begin
                    b_count <= b_dec;
                    flags[`F_Z] <= (b_dec == 8'h00);
                    hl_reg <= hl_reg + 16'h0001;
                    if (repeat_reg && b_dec != 8'h00)
                    begin
                        t_states <= `T_BLK_REP;
                        m_cycles <= `M_BLK_REP;
                        state_reg <= S_BLK_WAIT;
                    end
                    else
                    begin
                        t_states <= `T_BLK_LAST;
                        m_cycles <= `M_BLK_LAST;
                        program_counter <= program_counter + 16'h0002;
                        done <= 1'b1;
                        op_ready <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
    // ****************************************
    // buffered input words
    // ****************************************
    // output register keeps the top-level port straight from a flop
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            in_word <= 8'h00;
            in_word_valid <= 1'b0;
        end
        else if (!in_word_valid && fifo_out_valid && in_word_ready)
        begin
            in_word <= fifo_out_data;
            in_word_valid <= 1'b1;
        end
        else
            in_word_valid <= 1'b0;
    end
endmodule // flow_exec

// ### flow_exec_assertions.sv
// checker for jump, call, return and port timing
module flow_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] op_arg1,
    input wire logic [7:0] op_arg2,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire logic [7:0] acc_in,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] stack_pointer,
    input wire logic [7:0] flags,
    input wire logic [7:0] b_count,
    input wire logic interrupt_enable_primary,
    input wire logic interrupt_enable_shadow,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic mem_wr,
    input wire logic io_wr,
    input wire logic [4:0] t_states,
    input wire logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic take;
    logic [15:0] pc_t, sp_t, ret_pc, disp;
    logic [7:0] op_t, a1_t, a2_t, acc_t, b_t, f_t;
    assign take = op_valid && op_ready;
    assign ret_pc = pc_t + 16'h0003;
    assign disp = {{8{a1_t[7]}}, a1_t};
    // snapshot of the accepted instruction, compared against later
    always @(posedge sys_clk)
    begin
        if (take)
        begin
            pc_t <= program_counter;
            sp_t <= stack_pointer;
            op_t <= op_byte;
            a1_t <= op_arg1;
            a2_t <= op_arg2;
            acc_t <= acc_in;
            b_t <= b_count;
            f_t <= flags;
        end
    end
    jump_rel_target_a: assert property (take && op_byte == 8'h18 |=>
        done && program_counter == pc_t + 16'h0002 + disp && flags == f_t)
        else $error("relative jump target wrong");
    call_push_high_a: assert property (take && op_byte == 8'hCD |=> ##1
        mem_wr && bus_addr == sp_t - 16'h0001 && bus_wdata == ret_pc[15:8])
        else $error("call high byte push wrong");
    call_push_low_a: assert property (take && op_byte == 8'hCD |=> ##2
        mem_wr && bus_addr == sp_t - 16'h0002 && bus_wdata == ret_pc[7:0]
        && done && program_counter == {a2_t, a1_t} && flags == f_t)
        else $error("call low byte push or target wrong");
    restart_vector_a: assert property (take && op_byte[7:6] == 2'b11 &&
        op_byte[2:0] == 3'b111 |=> ##2
        done && program_counter == {10'h000, op_t[5:3], 3'b000})
        else $error("restart vector wrong");
    ret_pop_a: assert property (take && op_byte == 8'hC9 |=> ##3 done &&
        stack_pointer == sp_t + 16'h0002 && t_states == 5'h0A)
        else $error("return pop wrong");
    port_out_a: assert property (take && op_byte == 8'hD3 |=> io_wr &&
        bus_addr == {acc_t, a1_t} && bus_wdata == acc_t && done)
        else $error("port output address or data wrong");
    nm_exit_a: assert property (take && op_byte == 8'hED &&
        op_arg1 == 8'h45 |=> ##[1:3] done &&
        interrupt_enable_primary == interrupt_enable_shadow)
        else $error("service exit enable copy wrong");
    loop_branch_a: assert property (take && op_byte == 8'h10 |=> done &&
        b_count == b_t - 8'h01 && program_counter == pc_t + 16'h0002 +
        (b_t == 8'h01 ? 16'h0000 : disp))
        else $error("loop branch wrong");
    cover property (take && op_byte == 8'hED && op_arg1 == 8'hB2);
    cover property (take && op_byte == 8'hCD);
    cover property (take && op_byte == 8'h10);
endmodule // flow_chk

bind flow_exec flow_chk u_flow_chk (.*);

// ### mem_io_model.sv
// memory and port device facing the execution block
module mem_io_model (
    input wire logic sys_clk,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic io_rd,
    output logic [7:0] mem_rdata,
    output logic [7:0] port_rdata,
    output logic in_word_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [0:255];
    logic [7:0] cnt = 8'h00;
    initial mem_rdata = 8'h00;
    initial for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    // read data only in the cycle after the strobe, otherwise toggling
    always @(posedge sys_clk)
    begin
        cnt <= cnt + 8'h01;
        if (mem_wr)
            ram[bus_addr[7:0]] <= bus_wdata;
        mem_rdata <= mem_rd ? ram[bus_addr[7:0]] : ~mem_rdata;
    end
    // port data only while strobed, free-running count otherwise; sink stalls one cycle in four
    assign port_rdata = io_rd ? bus_addr[15:8] ^ 8'h3C : cnt;
    assign in_word_ready = cnt[1:0] != 2'b00;
endmodule // mem_io_model

// ### tb_top.sv
// testbench running instruction sequences through the execution block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] op_byte = 8'h00, op_arg1 = 8'h00, op_arg2 = 8'h00;
    logic [7:0] acc_in = 8'h9C;
    logic op_valid = 1'b0, nmi_entry = 1'b0, ei_set = 1'b0, di_clr = 1'b0;
    logic op_ready, mem_wr, mem_rd, io_wr, io_rd, done, in_word_valid;
    logic in_word_ready, interrupt_enable_primary, interrupt_enable_shadow;
    logic [7:0] mem_rdata, port_rdata, flags, b_count, bus_wdata, in_word;
    logic [15:0] program_counter, stack_pointer, bus_addr, pc_s;
    logic [4:0] t_states;
    logic [2:0] m_cycles;
    int err_count = 0;
    int total_checks = 0;
    int words = 0;
    // count words handed out of the input buffer
    always @(posedge sys_clk)
        if (in_word_valid === 1'b1) words++;
    always #20 sys_clk = ~sys_clk;
    flow_exec u_flow_exec (.*);
    mem_io_model u_mem_io_model (.*);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // offer one instruction, wait for its completion under a bound
    task issue(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2);
        int n;
        n = 0;
        @(posedge sys_clk);
        op_byte <= op;
        op_arg1 <= a1;
        op_arg2 <= a2;
        op_valid <= 1'b1;
        // drop valid at the very edge that took it, never one later
        @(posedge sys_clk);
        while (op_ready !== 1'b1) @(posedge sys_clk);
        op_valid <= 1'b0;
        @(negedge sys_clk);
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 3000) err_count++;
    endtask
    // one-cycle pulse on di_clr, nmi_entry, ei_set
    task strobe(input logic [2:0] s);
        @(posedge sys_clk);
        {di_clr, nmi_entry, ei_set} <= s;
        @(posedge sys_clk);
        {di_clr, nmi_entry, ei_set} <= 3'b000;
        @(negedge sys_clk);
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the expected run of under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run;
    end
    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk(stack_pointer, 16'hFFFF);
        issue(8'h18, 8'h7F, 8'h00);
        chk(program_counter, 16'h0081);
        issue(8'h18, 8'h80, 8'h00);
        chk(program_counter, 16'h0003);
        issue(8'hCD, 8'h34, 8'h12);
        chk(program_counter, 16'h1234);
        chk(t_states, 5'h11);
        issue(8'hC9, 8'h00, 8'h00);
        chk(program_counter, 16'h0006);
        // all flags clear: even codes hold, odd codes fail
        for (int c = 0; c < 8; c++)
        begin
            pc_s = program_counter;
            issue({2'b11, c[2:0], 3'b100}, 8'h00, 8'h20);
            chk(program_counter, c[0] ? pc_s + 16'h0003 : 16'h2000);
            chk(t_states, c[0] ? 5'h0A : 5'h11);
            issue({2'b11, c[2:0], 3'b000}, 8'h00, 8'h00);
            chk(program_counter, pc_s + 16'h0003 + c[0]);
            chk(t_states, c[0] ? 5'h05 : 5'h0B);
        end
        for (int t = 0; t < 8; t++)
        begin
            issue({2'b11, t[2:0], 3'b111}, 8'h00, 8'h00);
            chk(program_counter, {10'h000, t[2:0], 3'b000});
            chk(flags, 8'h00);
        end
        strobe(3'b001);
        strobe(3'b010);
        chk(interrupt_enable_shadow, 1'b1);
        issue(8'hED, 8'h45, 8'h00);
        chk(interrupt_enable_primary, 1'b1);
        chk(t_states, 5'h0E);
        issue(8'hED, 8'h4D, 8'h00);
        chk(t_states, 5'h0E);
        strobe(3'b100);
        chk(interrupt_enable_primary, 1'b0);
        issue(8'hD3, 8'h42, 8'h00);
        chk(t_states, 5'h0B);
        issue(8'h10, 8'h10, 8'h00);
        chk(b_count, 8'hFF);
        issue(8'hED, 8'hA3, 8'h07);
        chk(flags[6], 1'b0);
        issue(8'hED, 8'hB2, 8'h07);
        chk(b_count, 8'h00);
        chk(flags[6], 1'b1);
        chk(m_cycles, 3'h4);
        repeat (40) @(negedge sys_clk);
        chk(words, 16'h00FE);
        chk(in_word, 8'h3D);
        complete_run;
    end
endmodule // tb_top
